// ==== inc/dwsp_pkg.sv ====
// constants and state type for the dual wiper serial shift port
// assumes the including design runs on one system clock
package dwsp_pkg;

  localparam int unsigned SR_W      = 17;     // shift register length
  localparam int unsigned WIPER_W   = 8;      // wiper code width
  localparam int unsigned SYNC_W    = 3;      // synchronised pin count

  // storage index = 16 - transfer position; index 16 drives the chain output
  localparam int unsigned SS_IDX    = 16;     // transfer position 0, stack select
  localparam int unsigned W1_MSB    = 15;     // transfer position 1
  localparam int unsigned W1_LSB    = 8;      // transfer position 8
  localparam int unsigned W0_MSB    = 7;      // transfer position 9
  localparam int unsigned W0_LSB    = 0;      // transfer position 16

  localparam logic [7:0]  WIPER_RST = 8'h80;  // mid-scale code
  localparam logic        SS_RST    = 1'h0;   // potentiometer zero selected
  localparam logic [16:0] SR_RST    = {SS_RST, WIPER_RST, WIPER_RST};

  // pin positions inside the synchroniser vector
  localparam int unsigned PIN_EN    = 0;
  localparam int unsigned PIN_CLK   = 1;
  localparam int unsigned PIN_DAT   = 2;

  typedef struct packed {
    logic [16:0] sr;       // serial shift register
    logic [7:0]  w0;       // wiper zero latch
    logic [7:0]  w1;       // wiper one latch
    logic        ss;       // stack select latch
    logic [7:0]  stk;      // stacked wiper selection
    logic        en_d;     // port enable, one cycle old
    logic        sclk_d;   // serial clock, one cycle old
  } dwsp_state_t;

endpackage

// ==== verilog/dwsp_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module dwsp_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk,    // system clock
  input  wire logic             rst_n,  // synchronous reset, active low
  input  wire logic [WIDTH-1:0] d,      // asynchronous pins
  output var  logic [WIDTH-1:0] q       // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // dwsp_sync

`default_nettype wire

// ==== verilog/dwsp_port.sv ====
// serial control port of a dual 256-step potentiometer: shift register,
// wiper latches, stacked wiper selection and cascade output
// assumes port enable, serial clock and data are asynchronous pins, and the
// serial clock runs far below the system clock (two samples per phase or more)
//
// Notes on behaviour
// - port enable low ignores clock and data
// - shift data in on serial clock rise
// - seventeen bit register, position zero stack select
// - positions one to eight: wiper one
// - positions nine to sixteen: wiper zero
// - port enable fall loads latches from register
// - power-up wipers at mid-scale code
// - stacked output follows latched stack select
// - enable rise shows last stage on chain
// - each clock rise while enabled advances chain output stage
// - stack select bit leaves chain first
// - chain output driven regardless of enable
`timescale 1ns/1ps
`default_nettype none

module dwsp_port
  import dwsp_pkg::*;
(
  input  wire logic       clk,                // system clock, 200 MHz
  input  wire logic       rst_n,              // synchronous reset, active low
  input  wire logic       port_enable,        // port enable pin, high active
  input  wire logic       serial_clk,         // serial clock pin
  input  wire logic       serial_data_in,     // serial data pin
  output var  logic       chain_data_out,     // cascade output, last stage
  output var  logic [7:0] wiper_zero_tap,     // latched wiper zero code
  output var  logic [7:0] wiper_one_tap,      // latched wiper one code
  output var  logic       stack_select,       // latched stack select bit
  output var  logic [7:0] stacked_wiper_out   // code of the selected wiper
);

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic              en_s;
  logic              sclk_s;
  logic              din_s;
  logic              sclk_rise;
  logic              en_fall;
  dwsp_state_t       st_reg;
  dwsp_state_t       st_next;

  assign pins_raw[PIN_EN]  = port_enable;
  assign pins_raw[PIN_CLK] = serial_clk;
  assign pins_raw[PIN_DAT] = serial_data_in;

  dwsp_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign en_s      = pins_s[PIN_EN];
  assign sclk_s    = pins_s[PIN_CLK];
  assign din_s     = pins_s[PIN_DAT];

  // edges seen on the synchronised levels only
  assign sclk_rise = sclk_s && !st_reg.sclk_d;
  assign en_fall   = st_reg.en_d && !en_s;

  always_comb
  begin
    st_next        = st_reg;
    st_next.en_d   = en_s;
    st_next.sclk_d = sclk_s;

    // shifting only while the port is selected
    if (en_s && sclk_rise)
    begin
      st_next.sr = {st_reg.sr[SR_W-2:0], din_s};
    end

    // latches change only when the port is deselected
    if (en_fall)
    begin
      st_next.ss = st_reg.sr[SS_IDX];
      st_next.w1 = st_reg.sr[W1_MSB:W1_LSB];
      st_next.w0 = st_reg.sr[W0_MSB:W0_LSB];
    end

    st_next.stk = st_next.ss ? st_next.w1 : st_next.w0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg.sr     <= SR_RST;
      st_reg.w0     <= WIPER_RST;
      st_reg.w1     <= WIPER_RST;
      st_reg.ss     <= SS_RST;
      st_reg.stk    <= WIPER_RST;
      st_reg.en_d   <= 1'h0;
      st_reg.sclk_d <= 1'h0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // chain output is the last stage at all times
  assign chain_data_out    = st_reg.sr[SS_IDX];
  assign wiper_zero_tap    = st_reg.w0;
  assign wiper_one_tap     = st_reg.w1;
  assign stack_select      = st_reg.ss;
  assign stacked_wiper_out = st_reg.stk;

  idle_hold_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    !en_s |=> $stable(st_reg.sr))
    else $error("shift register moved while port disabled");

  shift_step_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    (en_s && sclk_rise) |=> (st_reg.sr == {$past(st_reg.sr[15:0]), $past(din_s)}))
    else $error("shift register did not take the data bit");

  chain_next_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    (en_s && sclk_rise) |=> (chain_data_out == $past(st_reg.sr[15])))
    else $error("chain output did not advance one stage");

  chain_drive_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    !en_s |=> (chain_data_out == $past(chain_data_out)))
    else $error("chain output changed while port disabled");

  latch_load_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    en_fall |=> ((wiper_one_tap == $past(st_reg.sr[15:8]))
                 && (wiper_zero_tap == $past(st_reg.sr[7:0]))
                 && (stack_select == $past(st_reg.sr[16]))))
    else $error("latches not loaded on port enable fall");

  latch_hold_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    !en_fall |=> ($stable(wiper_zero_tap) && $stable(wiper_one_tap)
                  && $stable(stack_select)))
    else $error("latches changed without port enable fall");

  reset_mid_a : assert property (
    @(posedge clk)
    !rst_n |=> ((wiper_zero_tap == 8'h80) && (wiper_one_tap == 8'h80)))
    else $error("wipers not at mid-scale after reset");

  stack_mux_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    stacked_wiper_out == (stack_select ? wiper_one_tap : wiper_zero_tap))
    else $error("stacked output does not follow stack select");

  select_first_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(en_s) |-> (chain_data_out == stack_select))
    else $error("stack select not first on chain output");

  recirc_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    en_fall |=> (stack_select == $past(chain_data_out)))
    else $error("stack select not taken from last stage");

  // clocking while deselected must leave register and chain alone
  no_shift_low_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    (!en_s && sclk_rise) |=> $stable(st_reg.sr))
    else $error("shift register moved on a clock while disabled");

  chain_quiet_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    (!en_s && sclk_rise) |=> $stable(chain_data_out))
    else $error("chain output moved on a clock while disabled");

  // selected port moves only on a detected clock rise
  one_step_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    (en_s && !sclk_rise) |=> $stable(st_reg.sr))
    else $error("shift register moved without a clock rise");

  chain_hold_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    (en_s && !sclk_rise) |=> $stable(chain_data_out))
    else $error("chain output moved without a clock rise");

  enable_rise_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(en_s) && !sclk_rise) |=> $stable(chain_data_out))
    else $error("chain output disturbed by port enable rise");

  // latches and stacked output move together, on the fall only
  shift_keep_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    en_s |=> ($stable(wiper_zero_tap) && $stable(wiper_one_tap) && $stable(stack_select)))
    else $error("latches changed while port enabled");

  fall_only_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(stack_select) |-> $past(en_fall))
    else $error("stack select changed without port enable fall");

  stack_load_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    en_fall |=> (stacked_wiper_out == ($past(st_reg.sr[16]) ? $past(st_reg.sr[15:8])
                                                             : $past(st_reg.sr[7:0]))))
    else $error("stacked output not updated with the latches");

  reset_state_a : assert property (
    @(posedge clk)
    !rst_n |=> ((stacked_wiper_out == 8'h80) && !stack_select && !chain_data_out))
    else $error("stacked output, select or chain not at reset value");

endmodule // dwsp_port

`default_nettype wire

// ==== testbench/dwsp_host_model.sv ====
// host side of the three-wire port: enable, serial clock and data
// assumes the bench clock clk; every pin changes on its falling edge, except data during readback, which follows chain_in
`timescale 1ns/1ps
`default_nettype none
module dwsp_host_model (
  input  wire logic clk,      // bench clock
  input  wire logic chain_in, // cascade output of the port
  output var  logic en,       // port enable
  output var  logic sck,      // serial clock, 125 ns period
  output wire logic dat       // serial data
);
  logic fb = 1'b0;
  logic drv = 1'b0;
  initial
  begin
    en = 1'b0;
    sck = 1'b0;
  end
  // readback leaves data to the feedback path
  assign dat = fb ? chain_in : drv;
  task automatic half(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bits w[n-1] down to w[0]; cap collects cascade samples
  task automatic xfer(input logic [16:0] w, input int n, input logic rb,
                      output logic [16:0] cap);
    cap = 17'h00000;
    fb = rb;
    en = 1'b1;
    half(12);
    for (int i = n - 1; i >= 0; i--)
    begin
      drv = w[i];
      half(12);
      cap = {cap[15:0], chain_in};
      sck = 1'b1;
      half(13);
      sck = 1'b0;
    end
    half(12);
    en = 1'b0;
    fb = 1'b0;
    half(25);
  endtask
  task automatic idle(input int n);
    for (int i = 0; i < n; i++)
    begin
      drv = 1'($urandom);
      half(12);
      sck = 1'b1;
      half(13);
      sck = 1'b0;
    end
  endtask
endmodule // dwsp_host_model
`default_nettype wire

// ==== testbench/test_dual_wiper_serial_shift_port.sv ====
// self-checking bench of the serial port against a host model
// assumes dwsp_port and dwsp_host_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_dual_wiper_serial_shift_port;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en, sck, dat, chain, ss;
  logic [7:0]  w0, w1, stk;
  logic [16:0] sr = 17'h08080;
  logic [16:0] cap, f;
  int          n_errors = 0;
  int          checked = 0;
  dwsp_host_model u_host (.clk(clk), .chain_in(chain), .en(en), .sck(sck), .dat(dat));
  dwsp_port u_dut (.clk(clk), .rst_n(rst_n), .port_enable(en), .serial_clk(sck),
    .serial_data_in(dat), .chain_data_out(chain), .wiper_zero_tap(w0),
    .wiper_one_tap(w1), .stack_select(ss), .stacked_wiper_out(stk));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up;
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // latched outputs against the modelled register
  task automatic chk_lat;
    cmp({ss, w1, w0}, sr);
    cmp(17'(stk), 17'(sr[16] ? sr[15:8] : sr[7:0]));
  endtask
  function automatic logic [16:0] shifted(input logic [16:0] o, input logic [16:0] w,
                                          input int n);
    for (int i = n - 1; i >= 0; i--)
      o = {o[15:0], w[i]};
    return o;
  endfunction
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(4150));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_lat();
    cmp(17'(chain), 17'h0);
    for (int k = 0; k < 8; k++)
    begin
      f = (k == 0) ? 17'h1ffff : (k == 1) ? 17'h00000 : 17'($urandom);
      fork
        u_host.xfer(f, 17, 1'b0, cap);
        begin
          repeat (300) @(negedge clk);
          chk_lat();
        end
      join
      cmp(cap, sr);
      sr = f;
      chk_lat();
    end
    f = 17'($urandom);
    u_host.xfer(f, 5, 1'b0, cap);
    cmp(cap, 17'(sr >> 12));
    sr = shifted(sr, f, 5);
    chk_lat();
    u_host.idle(20);
    chk_lat();
    cmp(17'(chain), 17'(sr[16]));
    u_host.xfer(17'h00000, 17, 1'b1, cap);
    cmp(cap, sr);
    chk_lat();
    wrap_up();
  end
endmodule // test_dual_wiper_serial_shift_port
`default_nettype wire
